// file: rtl/calibration_menu_controller.sv
// Summary of operation
// - power-on with seal keys held enters calibration
// - displays show step, sub-step and count
// - seal up/down presses change the count
// - advance key stores count, shows it, advances
// - advance without adjusting skips the sub-step
// - reset ends calibration; no unsaved writes
// - step 2 current: three sub-steps in order
// - step 3 voltage follows, same sub-steps
// - each sub-step starts with count 50
// - matching pedal activates output with count
// - stored counts go to nonvolatile memory
`timescale 1ns/1ps
module calibration_menu_controller
    import cal_menu_pkg::*;
#(
    parameter int unsigned SHOW_CYC = SHOW_CYC_DFLT
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire cal_menu_pkg::keys_type keys_pin,
    input wire cal_menu_pkg::chan_type pedal_pin,
    output cal_menu_pkg::disp_type disp,
    output cal_menu_pkg::chan_type act,
    output logic [cal_menu_pkg::CNT_W-1:0] act_count,
    output cal_menu_pkg::nv_wr_type nv_wr,
    output logic [cal_menu_pkg::TBL_N*cal_menu_pkg::CNT_W-1:0] cal_table,
    output logic run_mode,
    output logic cal_mode,
    output logic cal_done
);
    import cal_menu_pkg::*;

    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [IDX_W-1:0] tbl_idx(
        input logic [STEP_W-1:0] step,
        input logic [STEP_W-1:0] sub
    );
        logic [STEP_W-1:0] lin;
        lin = (step - STEP_CUR) * SUB_STRIDE + (sub - SUB_FIRST);
        return lin[IDX_W-1:0];
    endfunction

    function automatic chan_type sub_chan(input logic [STEP_W-1:0] sub);
        chan_type c;
        c.fb = (sub == SUB_FIRST);
        c.cb = (sub == SUB_MID);
        c.vs = (sub == SUB_LAST);
        return c;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    keys_type keys_s1_r, keys_s2_r, keys_d_r;
    chan_type pedal_s1_r, pedal_s2_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            keys_s1_r <= '0;
            keys_s2_r <= '0;
            keys_d_r <= '0;
            pedal_s1_r <= '0;
            pedal_s2_r <= '0;
        end else begin
            keys_s1_r <= keys_pin;
            keys_s2_r <= keys_s1_r;
            keys_d_r <= keys_s2_r;
            pedal_s1_r <= pedal_pin;
            pedal_s2_r <= pedal_s1_r;
        end
    end

    keys_type press;
    assign press = keys_s2_r & ~keys_d_r;

    // ------------------------------------------------------------
    // menu state
    // ------------------------------------------------------------
    state_type state_r;
    logic [2:0] boot_cnt_r;
    logic [31:0] show_cnt_r;
    logic [STEP_W-1:0] step_r, sub_r;
    logic [CNT_W-1:0] count_r;
    logic adjusted_r;
    logic save, skip, show_end, adv, last;

    assign save = (state_r == ST_CAL) && press.fb_up && adjusted_r;
    assign skip = (state_r == ST_CAL) && press.fb_up && !adjusted_r;
    assign show_end = (state_r == ST_SHOW) && (show_cnt_r == 32'h0);
    assign adv = skip || show_end;
    assign last = (step_r == STEP_VOLT) && (sub_r == SUB_LAST);

    // keys are sampled after the synchroniser settles, so the strap
    // is taken from clean levels rather than the first flop
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_r <= ST_BOOT;
            boot_cnt_r <= 3'h0;
            show_cnt_r <= 32'h0;
        end else begin
            unique case (state_r)
                ST_BOOT: begin
                    boot_cnt_r <= boot_cnt_r + 3'h1;
                    if (boot_cnt_r == BOOT_CYC) begin
                        if (keys_s2_r.vs_up && keys_s2_r.vs_dn) begin
                            state_r <= ST_CAL;
                        end else begin
                            state_r <= ST_RUN;
                        end
                    end
                end
                ST_RUN: begin
                    state_r <= ST_RUN;
                end
                ST_CAL: begin
                    if (save) begin
                        state_r <= ST_SHOW;
                        show_cnt_r <= 32'(SHOW_CYC - 1);
                    end else if (skip && last) begin
                        state_r <= ST_DONE;
                    end
                end
                ST_SHOW: begin
                    show_cnt_r <= show_cnt_r - 32'h1;
                    if (show_end) begin
                        state_r <= last ? ST_DONE : ST_CAL;
                    end
                end
                ST_DONE: begin
                    state_r <= ST_DONE;
                end
                default: begin
                    state_r <= ST_BOOT;
                end
            endcase
        end
    end

    // voltage step follows with same order
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            step_r <= STEP_CUR;
            sub_r <= SUB_FIRST;
        end else if (adv) begin
            if (sub_r != SUB_LAST) begin
                sub_r <= sub_r + 4'h1;
            end else if (step_r == STEP_CUR) begin
                step_r <= STEP_VOLT;
                sub_r <= SUB_FIRST;
            end else begin
                step_r <= STEP_POWER;
                sub_r <= SUB_FIRST;
            end
        end
    end

    // adjustable count; the advance key outranks the seal keys
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            count_r <= CNT_PRESET;
            adjusted_r <= 1'b0;
        end else if (adv) begin
            count_r <= CNT_PRESET;
            adjusted_r <= 1'b0;
        end else if (state_r == ST_CAL && !press.fb_up) begin
            if (press.vs_up) begin
                adjusted_r <= 1'b1;
                if (count_r != CNT_MAX) begin
                    count_r <= count_r + CNT_ONE;
                end
            end else if (press.vs_dn) begin
                adjusted_r <= 1'b1;
                if (count_r != CNT_MIN) begin
                    count_r <= count_r - CNT_ONE;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // stored data and nonvolatile write port
    // ------------------------------------------------------------
    logic [TBL_N*CNT_W-1:0] table_r;
    nv_wr_type nv_wr_r;

    // only saved sub-steps ever reach the table
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            table_r <= {TBL_N{CNT_PRESET}};
        end else if (save) begin
            table_r[tbl_idx(step_r, sub_r)*CNT_W +: CNT_W] <= count_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            nv_wr_r <= '0;
        end else begin
            nv_wr_r.valid <= save;
            nv_wr_r.index <= tbl_idx(step_r, sub_r);
            nv_wr_r.data <= count_r;
        end
    end

    // ------------------------------------------------------------
    // displays and output activation
    // ------------------------------------------------------------
    disp_type disp_r;
    chan_type act_r;
    logic [CNT_W-1:0] act_count_r;
    logic run_r, cal_r, done_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            disp_r <= '0;
        end else if (state_r == ST_BOOT || state_r == ST_RUN) begin
            disp_r <= '0;
        end else begin
            disp_r.step <= step_r;
            disp_r.sub <= sub_r;
            disp_r.value <= count_r;
        end
    end

    // activation is refused outside an adjusting sub-step, which
    // covers the hold time after a save
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            act_r <= '0;
            act_count_r <= '0;
        end else begin
            if (state_r == ST_CAL) begin
                act_r <= pedal_s2_r & sub_chan(sub_r);
            end else begin
                act_r <= '0;
            end
            act_count_r <= count_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            run_r <= 1'b0;
            cal_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            run_r <= (state_r == ST_RUN);
            cal_r <= (state_r == ST_CAL) || (state_r == ST_SHOW);
            done_r <= (state_r == ST_DONE);
        end
    end

    assign disp = disp_r;
    assign act = act_r;
    assign act_count = act_count_r;
    assign nv_wr = nv_wr_r;
    assign cal_table = table_r;
    assign run_mode = run_r;
    assign cal_mode = cal_r;
    assign cal_done = done_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_entry_display: assert property (
        state_r == ST_CAL && $past(state_r) == ST_BOOT |=>
        disp_r.step == STEP_CUR && disp_r.sub == SUB_FIRST &&
        disp_r.value == CNT_PRESET)
        else $error("calibration entry display wrong");
    a_display_track: assert property (
        state_r == ST_CAL ##1 state_r == ST_CAL |->
        disp_r.step == $past(step_r) && disp_r.value == $past(count_r))
        else $error("display does not follow menu");
    a_count_up: assert property (
        state_r == ST_CAL && press.vs_up && !press.fb_up &&
        count_r != CNT_MAX |=> count_r == $past(count_r) + CNT_ONE)
        else $error("up key did not increment");
    a_count_down: assert property (
        state_r == ST_CAL && press.vs_dn && !press.vs_up &&
        !press.fb_up && count_r != CNT_MIN |=>
        count_r == $past(count_r) - CNT_ONE)
        else $error("down key did not decrement");
    a_save_write: assert property (
        save |=> nv_wr_r.valid && nv_wr_r.data == $past(count_r) &&
        state_r == ST_SHOW ##1 disp_r.value == $past(count_r, 2))
        else $error("save did not store and show count");
    a_skip_nowrite: assert property (
        skip |=> !nv_wr_r.valid && count_r == CNT_PRESET)
        else $error("skip wrote memory");
    a_step_order: assert property (
        adv && step_r == STEP_CUR && sub_r == SUB_LAST |=>
        step_r == STEP_VOLT && sub_r == SUB_FIRST)
        else $error("voltage step did not follow");
    a_sub_order: assert property (
        adv && sub_r != SUB_LAST |=> sub_r == $past(sub_r) + 4'h1 &&
        $stable(step_r))
        else $error("sub-step order broken");
    a_preset_entry: assert property (
        adv |=> count_r == CNT_PRESET && !adjusted_r)
        else $error("sub-step count not preset");
    a_pedal_act: assert property (
        state_r == ST_CAL && pedal_s2_r.vs && sub_r == SUB_LAST |=>
        act_r.vs && act_count_r == $past(count_r))
        else $error("pedal did not activate output");
    a_run_idle: assert property (
        state_r == ST_RUN |=> act_r == '0 && !nv_wr_r.valid)
        else $error("run mode activity from calibration");
    a_count_sat: assert property (
        state_r == ST_CAL && count_r == CNT_MAX && press.vs_up &&
        !press.fb_up |=> count_r == CNT_MAX)
        else $error("count wrapped past maximum");

endmodule // calibration_menu_controller

// file: rtl/cal_menu_pkg.sv
package cal_menu_pkg;

    // ------------------------------------------------------------
    // widths and table shape
    // ------------------------------------------------------------
    localparam int CNT_W = 8;
    localparam int STEP_W = 4;
    localparam int TBL_N = 6;
    localparam int IDX_W = 3;
    localparam int SUBS_PER_STEP = 3;

    // ------------------------------------------------------------
    // menu positions and count limits
    // ------------------------------------------------------------
    localparam logic [STEP_W-1:0] STEP_CUR = 4'h2;
    localparam logic [STEP_W-1:0] STEP_VOLT = 4'h3;
    localparam logic [STEP_W-1:0] STEP_POWER = 4'h4;
    localparam logic [STEP_W-1:0] SUB_FIRST = 4'h1;
    localparam logic [STEP_W-1:0] SUB_MID = 4'h2;
    localparam logic [STEP_W-1:0] SUB_LAST = 4'h3;
    localparam logic [STEP_W-1:0] SUB_STRIDE = 4'h3;
    localparam logic [CNT_W-1:0] CNT_PRESET = 8'h32;
    localparam logic [CNT_W-1:0] CNT_MIN = 8'h00;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int SHOW_MS = 500;
    localparam int SHOW_CYC_DFLT = SHOW_MS * CLK_MHZ * 1000;
    localparam logic [2:0] BOOT_CYC = 3'h4;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic fb_up;
        logic vs_up;
        logic vs_dn;
    } keys_type;

    typedef struct packed {
        logic fb;
        logic cb;
        logic vs;
    } chan_type;

    typedef struct packed {
        logic [STEP_W-1:0] step;
        logic [STEP_W-1:0] sub;
        logic [CNT_W-1:0] value;
    } disp_type;

    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] index;
        logic [CNT_W-1:0] data;
    } nv_wr_type;

    typedef enum logic [4:0] {
        ST_BOOT = 5'b00001,
        ST_RUN = 5'b00010,
        ST_CAL = 5'b00100,
        ST_SHOW = 5'b01000,
        ST_DONE = 5'b10000
    } state_type;

endpackage

// file: sim/tech_panel.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// technician at the front panel: keys held or tapped, pedals
// ------------------------------------------------------------
module tech_panel
    import cal_menu_pkg::*;
(
    input wire logic clk_sys,
    input wire cal_menu_pkg::keys_type key_hold,
    input wire cal_menu_pkg::keys_type key_tap,
    input wire cal_menu_pkg::chan_type pedal_want,
    output cal_menu_pkg::keys_type keys_pin,
    output cal_menu_pkg::chan_type pedal_pin
);
    keys_type tap_r = '0;
    logic [2:0] tap_cnt_r = 3'h0;

    // a tap is held three cycles; new taps wait until it is over
    always_ff @(posedge clk_sys) begin
        if (tap_cnt_r != 3'h0) begin
            tap_cnt_r <= tap_cnt_r - 3'h1;
        end else if (key_tap != '0) begin
            tap_r <= key_tap;
            tap_cnt_r <= 3'h3;
        end
    end

    assign keys_pin = key_hold | ((tap_cnt_r != 3'h0) ? tap_r : '0);

    assign pedal_pin = pedal_want & {3{tap_cnt_r == 3'h0}};
endmodule // tech_panel

// file: sim/calibration_menu_controller_tb.sv
`timescale 1ns/1ps
module calibration_menu_controller_tb;
    import cal_menu_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    // short display hold keeps the run small
    localparam int unsigned SHOW_SIM = 4;
    localparam keys_type K_FB = 3'b100;
    localparam keys_type K_UP = 3'b010;
    localparam keys_type K_DN = 3'b001;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    keys_type key_hold = '0;
    keys_type key_tap = '0;
    chan_type pedal_want = '0;
    keys_type keys_pin;
    chan_type pedal_pin;
    disp_type disp;
    chan_type act;
    logic [CNT_W-1:0] act_count;
    nv_wr_type nv_wr;
    logic [TBL_N*CNT_W-1:0] cal_table;
    logic run_mode;
    logic cal_mode;
    logic cal_done;
    int err_total = 0;
    int checks = 0;
    int nv_cnt = 0;
    nv_wr_type nv_last = '0;

    always #2 clk_sys = ~clk_sys;

    tech_panel panel (.clk_sys(clk_sys), .key_hold(key_hold),
        .key_tap(key_tap), .pedal_want(pedal_want),
        .keys_pin(keys_pin), .pedal_pin(pedal_pin));

    calibration_menu_controller #(.SHOW_CYC(SHOW_SIM)) dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .keys_pin(keys_pin),
        .pedal_pin(pedal_pin), .disp(disp), .act(act),
        .act_count(act_count), .nv_wr(nv_wr), .cal_table(cal_table),
        .run_mode(run_mode), .cal_mode(cal_mode), .cal_done(cal_done));

    // the save pulse stands one cycle; catch every one of them
    always @(posedge clk_sys) begin
        if (nv_wr.valid === 1'b1) begin
            nv_cnt++;
            nv_last = nv_wr;
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wait_disp(input disp_type exp);
        int n;
        n = 0;
        while (disp !== exp && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        chk(48'(disp), 48'(exp));
        // a display that never arrived ends the run here
        if (disp !== exp) begin
            stop_test();
        end
    endtask

    // power cycle; seal keys held through boot when asked
    task automatic reset_dut(input logic hold);
        rst_b = 1'b0;
        key_hold = {1'b0, hold, hold};
        repeat (10) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (12) @(negedge clk_sys);
        key_hold = '0;
    endtask

    task automatic tap(input keys_type k);
        key_tap = k;
        @(negedge clk_sys);
        key_tap = '0;
        repeat (7) @(negedge clk_sys);
    endtask

    task automatic pedal(input chan_type p, input chan_type exp_act);
        pedal_want = p;
        repeat (5) @(negedge clk_sys);
        chk(48'(act), 48'(exp_act));
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic sc_run();
        reset_dut(1'b0);
        repeat (10) @(negedge clk_sys);
        chk(48'(run_mode), 48'h1);
        chk(48'(cal_mode), 48'h0);
    endtask

    task automatic sc_enter();
        reset_dut(1'b1);
        wait_disp({STEP_CUR, SUB_FIRST, CNT_PRESET});
        chk(48'(cal_mode), 48'h1);
        chk(48'(run_mode), 48'h0);
    endtask

    task automatic sc_adjust();
        repeat (3) tap(K_UP);
        tap(K_DN);
        wait_disp({STEP_CUR, SUB_FIRST, 8'h34});
        pedal(3'b100, 3'b100);
        chk(48'(act_count), 48'h34);
        pedal(3'b010, 3'b000);
        pedal(3'b000, 3'b000);
    endtask

    task automatic sc_save();
        tap(K_FB);
        chk(48'(nv_cnt), 48'h1);
        chk(48'(nv_last), 48'({1'b1, 3'h0, 8'h34}));
        chk(48'(cal_table[7:0]), 48'h34);
        wait_disp({STEP_CUR, SUB_MID, CNT_PRESET});
    endtask

    task automatic sc_skip();
        tap(K_FB);
        wait_disp({STEP_CUR, SUB_LAST, CNT_PRESET});
        chk(48'(nv_cnt), 48'h1);
        chk(48'(cal_table[15:8]), 48'(CNT_PRESET));
        pedal(3'b001, 3'b001);
        pedal(3'b000, 3'b000);
        tap(K_FB);
        wait_disp({STEP_VOLT, SUB_FIRST, CNT_PRESET});
    endtask

    task automatic sc_sat();
        repeat (51) tap(K_DN);
        wait_disp({STEP_VOLT, SUB_FIRST, CNT_MIN});
        repeat (256) tap(K_UP);
        wait_disp({STEP_VOLT, SUB_FIRST, CNT_MAX});
        tap(K_FB);
        chk(48'(nv_last), 48'({1'b1, 3'h3, CNT_MAX}));
        chk(48'(cal_table[31:24]), 48'(CNT_MAX));
        wait_disp({STEP_VOLT, SUB_MID, CNT_PRESET});
    endtask

    task automatic sc_done();
        tap(K_FB);
        wait_disp({STEP_VOLT, SUB_LAST, CNT_PRESET});
        tap(K_FB);
        wait_disp({STEP_POWER, SUB_FIRST, CNT_PRESET});
        chk(48'(cal_done), 48'h1);
        chk(48'(nv_cnt), 48'h2);
    endtask

    task automatic sc_off();
        sc_enter();
        tap(K_UP);
        reset_dut(1'b0);
        repeat (10) @(negedge clk_sys);
        chk(48'(nv_cnt), 48'h2);
        chk(48'(run_mode), 48'h1);
        chk(48'(cal_mode), 48'h0);
    endtask

    initial begin
        sc_run();
        sc_enter();
        sc_adjust();
        sc_save();
        sc_skip();
        sc_sat();
        sc_done();
        sc_off();
        stop_test();
    end
endmodule // calibration_menu_controller_tb
